// [verilog/ipc_irq_priority.sv]
// interrupt priority levels and external request pins, wishbone slave
// assumes synchronous request pins and a core that reports service
// Functional notes
// RL1: low priority bits, timer2 at 5 down
// RL2: high priority bits, ext3 at 7 down
// RL3: level is high bit joined with low
// RL4: ext2/ext3 low bits in control bits 3,7
// RL5: extended priority low bits 2..0, rest reserved
// RL6: ext3/ext2 pass only when enabled
// RL7: type bit 0 level, 1 falling edge
// RL8: edge flag sticks until cleared or serviced
// RL9: level mode flag mirrors inverted pin
// RL10: control register has single-bit access
// RL11: ext0/ext1 type and flags in timer control
// RL12: sample once per machine cycle, high-low
// RL13: requester holds each level one machine cycle
// RL14: ext0/ext1 edge flags clear on service
// RL15: 00 lowest, 11 highest level
// RL16: preempt only by strictly higher level
// RL17: ties resolved by fixed natural order
// RL18: pending needs flag and enable both
`timescale 1ns/1ns
`default_nettype none
module ipc_irq_priority #(
  parameter int MC_CLKS = ipc_pkg::MC_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] extRequestPin,
  input wire logic [5:0] otherReq,
  input wire logic serviceStart,
  input wire logic [2:0] serviceSrc,
  input wire logic serviceEnd,
  output logic irq,
  output ipc_pkg::ipc_arb_s arbOut
);
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] prioLo_q; // low priority bits
  logic [7:0] prioHi_q; // high priority bits
  logic [7:0] extPrio_q; // extended low bits
  logic [7:0] extCtrl_q; // ext2/ext3 control
  logic [7:0] tmrCtrl_q; // ext0/ext1 type and flags
  logic [7:0] srcEn_q; // enable of sources 0..5, natural order; ext2/ext3 use their control enables
  logic [7:0] irqStat_q; // sticky request events
  logic [7:0] irqMask_q; // mask for irq output
  logic [7:0] arbLvl_q; // arbitrated request
  logic [3:0] pinPrev_q; // previous machine cycle sample
  logic [7:0] mcCnt_q; // machine cycle divider
  logic [1:0] actLvl_q [4]; // nesting stack of levels
  logic [2:0] depth_q; // nesting depth
  logic ack_q;
  logic [31:0] rdat_q;
  ipc_pkg::ipc_arb_s arb_q;
  logic irq_q;

  logic wbReq; // new bus request
  logic wrEn; // byte0 write strobe
  logic [7:0] wbyte; // write byte
  logic mcTick; // once per machine cycle
  logic [3:0] fall; // detected falling edges
  logic [3:0] edgeMode; // per pin edge select
  logic [1:0] lvl [ipc_pkg::NSRC]; // per source level
  logic [7:0] pend; // pending sources
  ipc_pkg::ipc_arb_s arb_d;
  logic [1:0] curLvl; // running routine level
  logic running;
  logic [7:0] extCtrl_d; // next ext2/ext3 control
  logic [7:0] tmrCtrl_d; // next ext0/ext1 type and flags
  logic [7:0] statClr; // status bits written with one

  assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
  // a write lands at the edge where the master sees ack, while it still holds the request
  assign wrEn = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
  assign statClr = (wrEn && wb_adr_i == ipc_pkg::OFF_IRQ_STAT) ? wbyte : 8'h00;
  assign wbyte = wb_dat_i[7:0];
  assign mcTick = (mcCnt_q == 8'(MC_CLKS - 1));
  assign edgeMode = {extCtrl_q[ipc_pkg::XC_TYPE3], extCtrl_q[ipc_pkg::XC_TYPE2],
                     tmrCtrl_q[ipc_pkg::TC_TYPE1], tmrCtrl_q[ipc_pkg::TC_TYPE0]};

  ////////////////////////////////////////////////////////////////////
  // machine cycle divider
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mcCnt_q <= 8'h00;
    else if (mcTick)
      mcCnt_q <= 8'h00;
    else
      mcCnt_q <= mcCnt_q + 8'h01;
  end

  // pin sample once per machine cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pinPrev_q <= 4'hF;
    else if (mcTick)
      pinPrev_q <= extRequestPin; // see RL12
  end

  // high then low across two machine cycle samples; relies on see RL13
  assign fall = mcTick ? (pinPrev_q & ~extRequestPin) : 4'h0; // see RL12

  ////////////////////////////////////////////////////////////////////
  // plain configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prioLo_q <= ipc_pkg::RST_BYTE;
      prioHi_q <= ipc_pkg::RST_BYTE;
      extPrio_q <= ipc_pkg::RST_BYTE;
      srcEn_q <= ipc_pkg::RST_BYTE;
      irqMask_q <= ipc_pkg::RST_BYTE;
    end
    else if (wrEn)
    begin
      case (wb_adr_i)
        ipc_pkg::OFF_PRIO_LO: prioLo_q <= wbyte & 8'h3F; // see RL1
        ipc_pkg::OFF_PRIO_HI: prioHi_q <= wbyte; // see RL2
        ipc_pkg::OFF_EXT_PRIO: extPrio_q <= wbyte & ipc_pkg::EXT_PRIO_MASK; // see RL5
        ipc_pkg::OFF_SRC_EN: srcEn_q <= wbyte;
        ipc_pkg::OFF_IRQ_MASK: irqMask_q <= wbyte;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // ext2/ext3 control next value; byte, set-bit and clear-bit writes
  always_comb
  begin
    extCtrl_d = extCtrl_q;
    if (wrEn && wb_adr_i == ipc_pkg::OFF_EXT_CTRL)
      extCtrl_d = wbyte;
    else if (wrEn && wb_adr_i == ipc_pkg::OFF_BIT_SET)
      extCtrl_d = extCtrl_q | (8'h01 << wbyte[2:0]); // see RL10
    else if (wrEn && wb_adr_i == ipc_pkg::OFF_BIT_CLR)
      extCtrl_d = extCtrl_q & ~(8'h01 << wbyte[2:0]); // see RL10
    // service start clears edge flag
    if (serviceStart && serviceSrc == 3'(ipc_pkg::SRC_EXT2) && extCtrl_d[ipc_pkg::XC_TYPE2])
      extCtrl_d[ipc_pkg::XC_FLAG2] = 1'b0; // see RL8
    if (serviceStart && serviceSrc == 3'(ipc_pkg::SRC_EXT3) && extCtrl_d[ipc_pkg::XC_TYPE3])
      extCtrl_d[ipc_pkg::XC_FLAG3] = 1'b0; // see RL8
    // edge sets win over clears; level mode mirrors inverted pin
    if (extCtrl_d[ipc_pkg::XC_TYPE2])
      extCtrl_d[ipc_pkg::XC_FLAG2] = extCtrl_d[ipc_pkg::XC_FLAG2] | fall[2]; // see RL7
    else
      extCtrl_d[ipc_pkg::XC_FLAG2] = ~extRequestPin[2]; // see RL9
    if (extCtrl_d[ipc_pkg::XC_TYPE3])
      extCtrl_d[ipc_pkg::XC_FLAG3] = extCtrl_d[ipc_pkg::XC_FLAG3] | fall[3]; // see RL7
    else
      extCtrl_d[ipc_pkg::XC_FLAG3] = ~extRequestPin[3]; // see RL9
  end

  // ext2/ext3 control register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      extCtrl_q <= ipc_pkg::RST_BYTE;
    else
      extCtrl_q <= extCtrl_d;
  end

  // ext0/ext1 type and flags, next value
  always_comb
  begin
    tmrCtrl_d = tmrCtrl_q;
    if (wrEn && wb_adr_i == ipc_pkg::OFF_TMR_CTRL)
      tmrCtrl_d = wbyte & 8'h0F; // see RL11
    if (serviceStart && serviceSrc == 3'h0 && tmrCtrl_d[ipc_pkg::TC_TYPE0])
      tmrCtrl_d[ipc_pkg::TC_FLAG0] = 1'b0; // see RL14
    if (serviceStart && serviceSrc == 3'h2 && tmrCtrl_d[ipc_pkg::TC_TYPE1])
      tmrCtrl_d[ipc_pkg::TC_FLAG1] = 1'b0; // see RL14
    // an edge in the service cycle still sets the flag
    if (tmrCtrl_d[ipc_pkg::TC_TYPE0])
      tmrCtrl_d[ipc_pkg::TC_FLAG0] = tmrCtrl_d[ipc_pkg::TC_FLAG0] | fall[0]; // see RL12
    else
      tmrCtrl_d[ipc_pkg::TC_FLAG0] = ~extRequestPin[0]; // level mode follows inverted pin
    if (tmrCtrl_d[ipc_pkg::TC_TYPE1])
      tmrCtrl_d[ipc_pkg::TC_FLAG1] = tmrCtrl_d[ipc_pkg::TC_FLAG1] | fall[1]; // see RL12
    else
      tmrCtrl_d[ipc_pkg::TC_FLAG1] = ~extRequestPin[1]; // level mode follows inverted pin
  end

  // ext0/ext1 type and flags register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tmrCtrl_q <= ipc_pkg::RST_BYTE;
    else
      tmrCtrl_q <= tmrCtrl_d;
  end

  ////////////////////////////////////////////////////////////////////
  // level per source and pending set
  generate
    for (genvar i = 0; i < ipc_pkg::NSRC; i++)
    begin : g_lvl
      // bit positions in natural order 0..5 match the low register; see RL1
      if (i < 6)
      begin : g_core
        localparam int P = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 2 :
                           (i == 3) ? 3 : (i == 4) ? 4 : 5;
        assign lvl[i] = {prioHi_q[P], prioLo_q[P]}; // see RL3
      end
      else if (i == ipc_pkg::SRC_EXT2)
      begin : g_x2
        assign lvl[i] = {prioHi_q[i], extCtrl_q[ipc_pkg::XC_LO2]}; // see RL4
      end
      else
      begin : g_x3
        assign lvl[i] = {prioHi_q[i], extCtrl_q[ipc_pkg::XC_LO3]}; // see RL4
      end
    end
  endgenerate

  always_comb
  begin
    pend = 8'h00;
    pend[0] = tmrCtrl_q[ipc_pkg::TC_FLAG0] & srcEn_q[0]; // see RL18
    pend[1] = otherReq[0] & srcEn_q[1];
    pend[2] = tmrCtrl_q[ipc_pkg::TC_FLAG1] & srcEn_q[2];
    pend[3] = otherReq[1] & srcEn_q[3];
    pend[4] = otherReq[2] & srcEn_q[4];
    pend[5] = otherReq[3] & srcEn_q[5];
    pend[6] = extCtrl_q[ipc_pkg::XC_FLAG2] & extCtrl_q[ipc_pkg::XC_EN2]; // see RL6
    pend[7] = extCtrl_q[ipc_pkg::XC_FLAG3] & extCtrl_q[ipc_pkg::XC_EN3]; // see RL6
  end

  ////////////////////////////////////////////////////////////////////
  // arbitration: highest level, then lowest natural index
  assign running = (depth_q != 3'h0);
  assign curLvl = running ? actLvl_q[2'(depth_q - 3'h1)] : 2'h0;

  always_comb
  begin
    arb_d = '0;
    for (int i = ipc_pkg::NSRC - 1; i >= 0; i--)
    begin
      // >= with descending index keeps lowest index on ties; see RL17
      if (pend[i] && (!arb_d.valid || lvl[i] >= arb_d.level))
      begin
        arb_d.valid = 1'b1;
        arb_d.level = lvl[i]; // 00 lowest, 11 highest; see RL15
        arb_d.src = 3'(i);
      end
    end
    // while serviced, only a strictly higher level gets through; see RL16
    if (running && arb_d.level <= curLvl)
      arb_d.valid = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      arb_q <= '0;
    else
      arb_q <= arb_d;
  end

  // nesting stack of running levels
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      depth_q <= 3'h0;
      for (int k = 0; k < 4; k++)
        actLvl_q[k] <= 2'h0;
    end
    else if (serviceStart && depth_q < 3'h4)
    begin
      actLvl_q[2'(depth_q)] <= lvl[serviceSrc]; // see RL16
      depth_q <= depth_q + 3'h1;
    end
    else if (serviceEnd && running)
      depth_q <= depth_q - 3'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status of pin events, write one to clear, set wins
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irqStat_q <= ipc_pkg::RST_BYTE;
    else
      irqStat_q <= (irqStat_q & ~statClr) | {4'h0, fall};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else
      irq_q <= |(irqStat_q & irqMask_q);
  end

  ////////////////////////////////////////////////////////////////////
  // bus answer: one cycle after the request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wbReq;
      if (wbReq && !wb_we_i)
      begin
        case (wb_adr_i)
          ipc_pkg::OFF_PRIO_LO: rdat_q <= {24'h0, prioLo_q};
          ipc_pkg::OFF_PRIO_HI: rdat_q <= {24'h0, prioHi_q};
          ipc_pkg::OFF_EXT_PRIO: rdat_q <= {24'h0, extPrio_q};
          ipc_pkg::OFF_EXT_CTRL: rdat_q <= {24'h0, extCtrl_q};
          ipc_pkg::OFF_TMR_CTRL: rdat_q <= {24'h0, tmrCtrl_q};
          ipc_pkg::OFF_SRC_EN: rdat_q <= {24'h0, srcEn_q};
          ipc_pkg::OFF_IRQ_STAT: rdat_q <= {24'h0, irqStat_q};
          ipc_pkg::OFF_IRQ_MASK: rdat_q <= {24'h0, irqMask_q};
          ipc_pkg::OFF_ARB: rdat_q <= {21'h0, depth_q, 2'h0, arb_q};
          default: rdat_q <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq = irq_q;
  assign arbOut = arb_q;
endmodule
`default_nettype wire

// [verilog/ipc_pkg.sv]
// package of the interrupt priority and external request block
// assumes a 32-bit classic wishbone bus with byte addresses
package ipc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_PRIO_LO = 8'hB8;
  localparam logic [7:0] OFF_PRIO_HI = 8'hBA;
  localparam logic [7:0] OFF_EXT_PRIO = 8'hBC;
  localparam logic [7:0] OFF_EXT_CTRL = 8'hC0;
  localparam logic [7:0] OFF_TMR_CTRL = 8'h88;
  localparam logic [7:0] OFF_SRC_EN = 8'hA8;
  localparam logic [7:0] OFF_IRQ_STAT = 8'hD0;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hD4;
  localparam logic [7:0] OFF_SERVICE = 8'hD8;
  localparam logic [7:0] OFF_BIT_SET = 8'hE0;
  localparam logic [7:0] OFF_BIT_CLR = 8'hE4;
  localparam logic [7:0] OFF_ARB = 8'hE8;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ext_request_control field positions
  localparam int XC_TYPE2 = 0;
  localparam int XC_FLAG2 = 1;
  localparam int XC_EN2 = 2;
  localparam int XC_LO2 = 3;
  localparam int XC_TYPE3 = 4;
  localparam int XC_FLAG3 = 5;
  localparam int XC_EN3 = 6;
  localparam int XC_LO3 = 7;
  // timer_control_reg field positions
  localparam int TC_TYPE0 = 0;
  localparam int TC_FLAG0 = 1;
  localparam int TC_TYPE1 = 2;
  localparam int TC_FLAG1 = 3;
  // extended priority writable mask
  localparam logic [7:0] EXT_PRIO_MASK = 8'h07;
  // source count and index order (natural order)
  localparam int NSRC = 8;
  localparam int SRC_EXT2 = 6;
  localparam int SRC_EXT3 = 7;
  // machine cycle length in clocks
  localparam int MC_CLKS = 12;
  // arbitration result
  typedef struct packed {
    logic valid;
    logic [1:0] level;
    logic [2:0] src;
  } ipc_arb_s;
endpackage

// [dv/ipc_irq_priority_sva.sv]
// port checker for the interrupt priority block
// assumes binding onto ipc_irq_priority, one clock domain
`timescale 1ns/1ns
`default_nettype none
module ipc_irq_priority_sva #(
  parameter int MC_CLKS = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [3:0] extRequestPin,
  input wire logic irq,
  input wire ipc_pkg::ipc_arb_s arbOut
);
  // read answer on the bus
  logic rd;
  assign rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  AST_HI_ZERO: assert property (rd && wb_adr_i != ipc_pkg::OFF_ARB |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_LO_RSVD: assert property (rd && wb_adr_i == ipc_pkg::OFF_PRIO_LO |-> wb_dat_o[7:6] == 2'h0)
    else $error("low priority spare bits set");
  AST_EXT_RSVD: assert property (rd && wb_adr_i == ipc_pkg::OFF_EXT_PRIO |-> wb_dat_o[7:3] == 5'h0)
    else $error("extended priority reserved bits set");
  AST_TMR_RSVD: assert property (rd && wb_adr_i == ipc_pkg::OFF_TMR_CTRL |-> wb_dat_o[7:4] == 4'h0)
    else $error("timer control spare bits set");
  AST_UNMAPPED: assert property (rd && wb_adr_i == ipc_pkg::OFF_SERVICE |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_LVL_MIRROR: assert property (rd && wb_adr_i == ipc_pkg::OFF_EXT_CTRL && !wb_dat_o[4]
    && $stable(extRequestPin[3]) && extRequestPin[3] == $past(extRequestPin[3], 4)
    |-> wb_dat_o[5] == !extRequestPin[3])
    else $error("level flag not inverse of pin");
  // main scenarios reached
  COV_WRITE: cover property (wb_ack_o && wb_we_i);
  COV_ARB: cover property (arbOut.valid);
  COV_IRQ: cover property (irq);
endmodule
bind ipc_irq_priority ipc_irq_priority_sva #(.MC_CLKS(MC_CLKS)) i_ipc_irq_priority_sva (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .extRequestPin(extRequestPin), .irq(irq), .arbOut(arbOut));
`default_nettype wire

// [dv/ipc_ext_dev.sv]
// model of the external devices on the four request pins
// assumes pins idle high and HOLD of at least one machine cycle
`timescale 1ns/1ns
`default_nettype none
module ipc_ext_dev #(
  parameter int HOLD = 6
) (
  input wire logic clk,
  output logic [3:0] extRequestPin
);
  // pins idle high until a device requests
  initial extRequestPin = 4'hF;
  // move one pin, then hold it so a sample can see it
  task automatic setPin(input int idx, input logic lvl);
    @(posedge clk);
    extRequestPin[idx] <= lvl;
    repeat (HOLD) @(posedge clk);
  endtask
  // one falling edge, then release high
  task automatic pulse(input int idx);
    setPin(idx, 1'b0);
    setPin(idx, 1'b1);
  endtask
endmodule
`default_nettype wire

// [dv/test_ipc_irq_priority.sv]
// self-checking bench for the interrupt priority block
// assumes the pin model and a shortened machine cycle
`timescale 1ns/1ns
`default_nettype none
module test_ipc_irq_priority;
  localparam int MC = 2;
  logic clk, rst_n, cyc, stb, we, ack, irq, sStart, sEnd;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] pins;
  logic [5:0] oreq;
  logic [2:0] sSrc;
  ipc_pkg::ipc_arb_s arb;
  int errTotal = 0;
  int checksDone = 0;
  ipc_irq_priority #(.MC_CLKS(MC)) i_ipc_irq_priority (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .extRequestPin(pins),
    .otherReq(oreq), .serviceStart(sStart), .serviceSrc(sSrc), .serviceEnd(sEnd),
    .irq(irq), .arbOut(arb));
  ipc_ext_dev #(.HOLD(3 * MC)) i_ipc_ext_dev (.clk(clk), .extRequestPin(pins));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    checksDone++;
    if (got !== exp)
    begin
      errTotal++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (ack !== 1'b1)
    begin
      errTotal++;
      tallyAndFinish();
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00);
    chk({24'h0, e}, q, what);
  endtask
  // service start or return of one source
  task automatic svc(input logic st, input logic [2:0] s);
    @(posedge clk);
    {sStart, sEnd, sSrc} <= {st, !st, s};
    @(posedge clk);
    {sStart, sEnd} <= 2'b00;
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic regsRst();
    rdChk(ipc_pkg::OFF_PRIO_HI, 8'h00, "hi reset");
    rdChk(ipc_pkg::OFF_EXT_PRIO, 8'h00, "ext reset");
    bus(1'b1, ipc_pkg::OFF_PRIO_HI, 8'hFF);
    rdChk(ipc_pkg::OFF_PRIO_HI, 8'hFF, "hi all");
    bus(1'b1, ipc_pkg::OFF_PRIO_HI, 8'h00);
    bus(1'b1, ipc_pkg::OFF_PRIO_LO, 8'hFF);
    rdChk(ipc_pkg::OFF_PRIO_LO, 8'h3F, "lo all");
    bus(1'b1, ipc_pkg::OFF_PRIO_LO, 8'h00);
    bus(1'b1, ipc_pkg::OFF_EXT_PRIO, 8'hFF);
    rdChk(ipc_pkg::OFF_EXT_PRIO, 8'h07, "ext all");
    bus(1'b1, ipc_pkg::OFF_SERVICE, 8'hFF);
    rdChk(ipc_pkg::OFF_SERVICE, 8'h00, "unmapped");
  endtask
  task automatic edgeExt2();
    bus(1'b1, ipc_pkg::OFF_EXT_CTRL, 8'h05);
    i_ipc_ext_dev.pulse(2);
    rdChk(ipc_pkg::OFF_EXT_CTRL, 8'h07, "edge flag sticks");
    chk(32'h0, {31'h0, irq}, "irq masked");
    bus(1'b1, ipc_pkg::OFF_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk);
    chk(32'h1, {31'h0, irq}, "irq raised");
    bus(1'b1, ipc_pkg::OFF_IRQ_STAT, 8'h04);
    repeat (2) @(posedge clk);
    chk(32'h0, {31'h0, irq}, "irq cleared");
    bus(1'b1, ipc_pkg::OFF_BIT_CLR, 8'h01);
    rdChk(ipc_pkg::OFF_EXT_CTRL, 8'h05, "flag bit clear");
  endtask
  task automatic lvlExt3();
    bus(1'b1, ipc_pkg::OFF_EXT_CTRL, 8'h00);
    i_ipc_ext_dev.setPin(3, 1'b0);
    chk(32'h0, {26'h0, arb}, "disabled ext3");
    bus(1'b1, ipc_pkg::OFF_BIT_SET, 8'h06);
    repeat (3) @(posedge clk);
    chk(32'h27, {26'h0, arb}, "enabled ext3");
    bus(1'b1, ipc_pkg::OFF_BIT_SET, 8'h07);
    repeat (3) @(posedge clk);
    chk(32'h2F, {26'h0, arb}, "ext3 low bit");
    bus(1'b1, ipc_pkg::OFF_PRIO_HI, 8'h80);
    repeat (3) @(posedge clk);
    chk(32'h3F, {26'h0, arb}, "ext3 high bit");
    rdChk(ipc_pkg::OFF_EXT_CTRL, 8'hE0, "level low");
    i_ipc_ext_dev.setPin(3, 1'b1);
    rdChk(ipc_pkg::OFF_EXT_CTRL, 8'hC0, "level high");
    bus(1'b1, ipc_pkg::OFF_EXT_CTRL, 8'h00);
  endtask
  task automatic ext0Svc();
    bus(1'b1, ipc_pkg::OFF_TMR_CTRL, 8'h01);
    i_ipc_ext_dev.pulse(0);
    rdChk(ipc_pkg::OFF_TMR_CTRL, 8'h03, "ext0 edge");
    svc(1'b1, 3'h0);
    svc(1'b0, 3'h0);
    rdChk(ipc_pkg::OFF_TMR_CTRL, 8'h01, "ext0 serviced");
  endtask
  task automatic arbTest();
    @(posedge clk);
    oreq <= 6'h03;
    repeat (3) @(posedge clk);
    chk(32'h0, {26'h0, arb}, "not enabled");
    bus(1'b1, ipc_pkg::OFF_SRC_EN, 8'h0A);
    repeat (3) @(posedge clk);
    chk(32'h21, {26'h0, arb}, "tie order");
    bus(1'b1, ipc_pkg::OFF_PRIO_HI, 8'h08);
    repeat (3) @(posedge clk);
    chk(32'h33, {26'h0, arb}, "level two");
    svc(1'b1, 3'h3);
    chk(32'h0, {31'h0, arb.valid}, "no preempt");
    svc(1'b0, 3'h3);
    chk(32'h33, {26'h0, arb}, "after return");
  endtask
  ////////////////////////////////////////
  initial
  begin
    {cyc, stb, we, adr, wdat} = '0;
    {oreq, sStart, sEnd, sSrc} = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    regsRst();
    edgeExt2();
    lvlExt3();
    ext0Svc();
    arbTest();
    tallyAndFinish();
  end
endmodule
`default_nettype wire
